// *** rtl/sgp_top.sv ***
// Switch-to-serial gain programmer: reads switches when a button is pressed and
// programs two daisy-chained gain amplifiers over a three-wire link.
// Assumes buttons and switches are asynchronous pins; link_clk is free running.
module sgp_top (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       link_clk,
  input  wire logic       read_button,
  input  wire logic       master_clear_button,
  input  wire logic [4:0] switches,
  output logic            sel_n,
  output logic            sclk,
  output logic            sdi,
  output logic            busy,
  output logic            code_rejected
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_SEND = 2'b01, C_WAIT = 2'b11} sgp_cst_t;
  typedef struct packed {
    sgp_cst_t    fsm;
    logic        rd_q;
    logic [7:0]  deb;
    logic [4:0]  code;
    logic [31:0] word;
    logic [5:0]  len;
    logic        start;
    logic        d1;
    logic        d2;
    logic        d3;
    logic        busy;
    logic        rej;
  } sgp_core_t;
  sgp_core_t st, next_st;

  logic       rd_s;
  logic       clr_s;
  logic [4:0] sw_s;
  logic       done_tgl;
  logic       core_rst;
  logic [2:0] lrst_sync;
  logic       link_rst;

  // Gain field value for index 0..7 maps to 1,2,4,5,8,10,16,32
  function automatic logic [7:0] gain_byte(input logic [2:0] idx);
    gain_byte = {5'h00, idx};
  endfunction

  function automatic logic [15:0] cmd_word(input logic [7:0] cmd, input logic [7:0] dat);
    cmd_word = {cmd, dat};
  endfunction

  sgp_sync u_rd (
    .clk  (core_clk),
    .srst (srst),
    .din  (read_button),
    .dout (rd_s)
  );

  sgp_sync u_clr (
    .clk  (core_clk),
    .srst (srst),
    .din  (master_clear_button),
    .dout (clr_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sw
      sgp_sync u_sw (
        .clk  (core_clk),
        .srst (srst),
        .din  (switches[gi]),
        .dout (sw_s[gi])
      );
    end
  endgenerate

  assign core_rst = srst | clr_s;

  // Reset carried into the link domain as a level through three flops
  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[1:0], core_rst};
  end
  assign link_rst = lrst_sync[2];

  always_comb begin
    next_st    = st;
    // Done toggle crosses through three flops; only the last two are compared
    next_st.d1 = done_tgl;
    next_st.d2 = st.d1;
    next_st.d3 = st.d2;
    next_st.rd_q = rd_s;
    if (st.deb != 8'h00) begin
      next_st.deb = st.deb - 8'h01;
    end
    case (st.fsm)
      C_IDLE: begin
        if (rd_s && !st.rd_q && st.deb == 8'h00) begin
          next_st.code = sw_s;
          next_st.deb  = sgp_pkg::DEB_CYC;
          next_st.fsm  = C_SEND;
        end
      end
      C_SEND: begin
        next_st.rej = 1'b0;
        next_st.fsm = C_WAIT;
        next_st.len = sgp_pkg::LEN_LONG;
        next_st.busy = 1'b1;
        next_st.start = ~st.start;
        // Downstream (single-channel) word goes first, upstream second
        if (st.code[4:3] == 2'b00) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_GAIN, gain_byte(st.code[2:0])), 16'h0000};
          next_st.len  = sgp_pkg::LEN_SHORT;
        end else if (st.code[4:3] == 2'b01) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_GAIN, gain_byte(st.code[2:0])),
                          cmd_word(sgp_pkg::CMD_NOP, 8'h00)};
        end else if (st.code[4:3] == 2'b10 && st.code <= sgp_pkg::CODE_CH5) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_CHAN, {5'h00, st.code[2:0]}), 16'h0000};
          next_st.len  = sgp_pkg::LEN_SHORT;
        end else if (st.code == sgp_pkg::CODE_PD_A) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_OFF, 8'h00), 16'h0000};
          next_st.len  = sgp_pkg::LEN_SHORT;
        end else if (st.code == sgp_pkg::CODE_PD_B) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_OFF, 8'h00), cmd_word(sgp_pkg::CMD_NOP, 8'h00)};
        end else if (st.code == sgp_pkg::CODE_PD_2) begin
          next_st.word = {cmd_word(sgp_pkg::CMD_OFF, 8'h00), cmd_word(sgp_pkg::CMD_OFF, 8'h00)};
        end else begin
          next_st.rej   = 1'b1;
          next_st.busy  = 1'b0;
          next_st.start = st.start;
          next_st.fsm   = C_IDLE;
        end
      end
      C_WAIT: begin
        if (st.d2 != st.d3) begin
          next_st.busy = 1'b0;
          next_st.fsm  = C_IDLE;
        end
      end
      default: begin
        next_st.fsm = C_IDLE;
      end
    endcase
    if (core_rst) begin
      next_st     = '0;
      next_st.fsm = C_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // Word and length are stable while the start toggle crosses and the link runs
  sgp_link u_link (
    .link_clk  (link_clk),
    .link_srst (link_rst),
    .start_tgl (st.start),
    .word      (st.word),
    .len       (st.len),
    .done_tgl  (done_tgl),
    .sel_n     (sel_n),
    .sclk      (sclk),
    .sdi       (sdi)
  );

  assign busy          = st.busy;
  assign code_rejected = st.rej;
endmodule

// *** inc/sgp_pkg.sv ***
// Constants for the switch-to-serial gain programmer.
// Assumes a core clock of 100 MHz and a separate free-running link clock.
package sgp_pkg;
  localparam int unsigned SW_W      = 5;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned CNT_W     = 6;
  localparam logic [5:0]  LEN_SHORT = 6'h10;
  localparam logic [5:0]  LEN_LONG  = 6'h20;
  // Amplifier instruction bytes
  localparam logic [7:0]  CMD_NOP   = 8'h00;
  localparam logic [7:0]  CMD_OFF   = 8'h20;
  localparam logic [7:0]  CMD_GAIN  = 8'h40;
  localparam logic [7:0]  CMD_CHAN  = 8'h41;
  localparam logic [4:0]  CODE_PD_A = 5'h18;
  localparam logic [4:0]  CODE_PD_B = 5'h19;
  localparam logic [4:0]  CODE_PD_2 = 5'h1A;
  localparam logic [4:0]  CODE_CH5  = 5'h15;
  // Button debounce time and cycles
  localparam int unsigned DEB_US    = 1;
  localparam int unsigned CLK_MHZ   = 100;
  localparam logic [7:0]  DEB_CYC   = 8'(DEB_US * CLK_MHZ);
  localparam logic [1:0]  SYNC_RST  = 2'h0;
endpackage

// *** rtl/sgp_sync.sv ***
// Three-flop pin synchroniser; the output changes once stages two and three agree.
// Assumes the input is asynchronous to clk.
module sgp_sync (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sgp_sync_t;
  sgp_sync_t st, next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign dout = st.q;
endmodule

// *** rtl/sgp_link.sv ***
// Link-side shifter in the serial clock domain: drives select, clock and data.
// Assumes a free-running link clock; start arrives as a toggle, done returns as a toggle.
module sgp_link (
  input  wire logic        link_clk,
  input  wire logic        link_srst,
  input  wire logic        start_tgl,
  input  wire logic [31:0] word,
  input  wire logic [5:0]  len,
  output logic             done_tgl,
  output logic             sel_n,
  output logic             sclk,
  output logic             sdi
);
  typedef enum logic [1:0] {L_IDLE = 2'b00, L_LOW = 2'b01, L_HIGH = 2'b11, L_END = 2'b10} sgp_lst_t;
  typedef struct packed {
    logic        t1;
    logic        t2;
    logic        t3;
    sgp_lst_t    fsm;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic        done;
    logic        sel_n;
    logic        sclk;
    logic        sdi;
  } sgp_link_t;
  sgp_link_t st, next_st;

  always_comb begin
    next_st    = st;
    next_st.t1 = start_tgl;
    next_st.t2 = st.t1;
    next_st.t3 = st.t2;
    case (st.fsm)
      L_IDLE: begin
        if (st.t2 != st.t3) begin
          next_st.sh    = word;
          next_st.cnt   = len;
          next_st.sel_n = 1'b0;
          next_st.fsm   = L_LOW;
        end
      end
      L_LOW: begin
        next_st.sclk = 1'b0;
        next_st.sdi  = st.sh[31];
        next_st.sh   = {st.sh[30:0], 1'b0};
        next_st.fsm  = L_HIGH;
      end
      L_HIGH: begin
        next_st.sclk = 1'b1;
        next_st.cnt  = st.cnt - 6'h01;
        next_st.fsm  = (st.cnt == 6'h01) ? L_END : L_LOW;
      end
      L_END: begin
        next_st.sclk  = 1'b0;
        next_st.sel_n = 1'b1;
        next_st.done  = ~st.done;
        next_st.fsm   = L_IDLE;
      end
      default: begin
        next_st.fsm = L_IDLE;
      end
    endcase
    if (link_srst) begin
      next_st       = '0;
      next_st.sel_n = 1'b1;
      next_st.fsm   = L_IDLE;
    end
  end

  always_ff @(posedge link_clk) begin
    st <= next_st;
  end

  assign done_tgl = st.done;
  assign sel_n    = st.sel_n;
  assign sclk     = st.sclk;
  assign sdi      = st.sdi;
endmodule

// *** dv/sgp_top_assertions.sv ***
// Port checker for the gain programmer.
// Assumes it is bound to sgp_top.
module sgp_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic read_button,
  input wire logic master_clear_button,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic busy,
  input wire logic code_rejected
);
  timeunit 1ns;
  timeprecision 100ps;
  wire        clr = srst | master_clear_button;
  logic [6:0] low;
  // Link cycles spent with select low
  always_ff @(posedge link_clk) begin
    low <= (clr | sel_n) ? 7'h00 : low + 7'h01;
  end
  a_frame_len: assert property (@(posedge link_clk) disable iff (clr)
    $rose(sel_n) |-> low == 7'h21 || low == 7'h41) else $error("bad frame length");
  a_sclk_idle: assert property (@(posedge link_clk) disable iff (clr)
    sel_n |-> !sclk) else $error("clock moved while deselected");
  a_sdi_hold: assert property (@(posedge link_clk) disable iff (clr)
    sclk |-> $stable(sdi)) else $error("data moved while clock high");
  a_sclk_alt: assert property (@(posedge link_clk) disable iff (clr)
    !sel_n && sclk |=> !sclk) else $error("clock high too long");
  a_busy_cause: assert property (@(posedge core_clk) disable iff (clr)
    $rose(busy) |-> $past(read_button, 3)) else $error("busy without press");
  a_busy_ends: assert property (@(posedge core_clk) disable iff (clr)
    $rose(busy) |-> ##[1:120] !busy) else $error("transfer never ends");
  a_reject_quiet: assert property (@(posedge core_clk) disable iff (clr)
    $rose(code_rejected) |-> (!busy && sel_n) [*8]) else $error("rejected code sent");
  a_clear_idle: assert property (@(posedge core_clk) disable iff (srst)
    master_clear_button [*8] |-> !busy && sel_n) else $error("clear left link active");
  a_sel_busy: assert property (@(posedge core_clk) disable iff (clr)
    !sel_n |-> busy) else $error("select low while idle");
  c_long: cover property (@(posedge link_clk) $rose(sel_n) && low == 7'h41);
  c_short: cover property (@(posedge link_clk) $rose(sel_n) && low == 7'h21);
  c_reject: cover property (@(posedge core_clk) $rose(code_rejected));
endmodule

bind sgp_top sgp_chk u_sgp_chk (.*);

// *** dv/sgp_amp_pair.sv ***
// Two chained amplifiers as seen from the link.
// Assumes select, clock and data from the programmer.
module sgp_amp_pair (
  input wire logic    sel_n,
  input wire logic    sclk,
  input wire logic    sdi,
  output logic [15:0] six_word,
  output logic [15:0] one_word,
  output int          bits,
  output int          frames
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh6;
  logic [15:0] sh1;
  int          n = 0;
  // Power-up state: first channel, unity gain
  initial begin
    six_word = 16'h0000;
    one_word = 16'h0000;
    frames = 0;
  end
  always @(posedge sclk) begin
    if (!sel_n) begin
      sh1 <= {sh1[14:0], sh6[15]};
      sh6 <= {sh6[14:0], sdi};
      n <= n + 1;
    end
  end
  always @(posedge sel_n) begin
    six_word <= sh6;
    one_word <= sh1;
    bits <= n;
    n <= 0;
    frames <= frames + 1;
  end
endmodule

// *** dv/test_switch_to_serial_gain_programmer.sv ***
// Self-checking bench for the gain programmer.
// Assumes the chained amplifier model at the link.
module test_switch_to_serial_gain_programmer;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic read_button = 1'b0;
  logic master_clear_button = 1'b0;
  logic [4:0] switches = 5'h00;
  logic sel_n, sclk, sdi, busy, code_rejected;
  logic [15:0] six_word, one_word;
  int bits, frames, bad_count = 0, checks = 0;
  sgp_top u_sgp_top (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .read_button(read_button), .master_clear_button(master_clear_button),
    .switches(switches), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .busy(busy),
    .code_rejected(code_rejected));
  sgp_amp_pair u_sgp_amp_pair (.sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .six_word(six_word), .one_word(one_word), .bits(bits), .frames(frames));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // {sent, length, downstream word, upstream word}
  function automatic logic [38:0] expect_of(input logic [4:0] c);
    logic [15:0] w;
    logic [15:0] s;
    w = {c[4] ? sgp_pkg::CMD_CHAN : sgp_pkg::CMD_GAIN, 5'h00, c[2:0]};
    s = {sgp_pkg::CMD_OFF, 8'h00};
    case (c) inside
      [5'h00:5'h07], [5'h10:5'h15]: return {7'h50, 16'h0000, w};
      [5'h08:5'h0F]: return {7'h60, w, 16'h0000};
      5'h18: return {7'h50, 16'h0000, s};
      5'h19: return {7'h60, s, 16'h0000};
      5'h1A: return {7'h60, s, s};
      default: return 39'h0;
    endcase
  endfunction
  task automatic run(input logic [4:0] c);
    logic [38:0] e;
    int f;
    int n;
    e = expect_of(c);
    f = frames;
    n = 0;
    switches <= c;
    @(posedge core_clk) read_button <= 1'b1;
    repeat (12) @(posedge core_clk);
    check("busy", busy, e[38]);
    switches <= ~c;
    while (busy !== 1'b0 && n < 150) begin
      @(posedge core_clk);
      n++;
    end
    check("busy end", busy, 1'b0);
    read_button <= 1'b0;
    repeat (110) @(posedge core_clk);
    check("rejected", code_rejected, !e[38]);
    check("frames", frames - f, e[38]);
    if (e[38]) begin
      check("bits", bits, e[37:32]);
      check("six word", six_word, e[15:0]);
      if (e[37]) check("one word", one_word, e[31:16]);
    end
  endtask
  initial begin
    void'($urandom(54));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (int c = 0; c < 32; c++) run(5'(c));
    switches <= 5'h1A;
    @(posedge core_clk) read_button <= 1'b1;
    repeat (20) @(posedge core_clk);
    master_clear_button <= 1'b1;
    read_button <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("clear busy", busy, 1'b0);
    check("clear sel", sel_n, 1'b1);
    master_clear_button <= 1'b0;
    repeat (110) @(posedge core_clk);
    repeat (12) run(5'($urandom));
    final_report();
  end
  initial begin
    #300us;
    bad_count++;
    final_report();
  end
endmodule
